/* verilog/cmsld_pkg.sv */
// Purpose: Shared constants and types for the charge mode select block.
// Assumes: A 100 MHz clock; load comparator inputs arrive from analog pins.
// Notes:   Times are kept in their own units and converted to cycles here.
`default_nettype none
package cmsld_pkg;
    // Clock rate in hertz.
    localparam longint unsigned CLK_HZ = 64'd100000000;
    // Documented times, in milliseconds.
    localparam longint unsigned PW_HOLD_MS = 64'd2000;
    localparam longint unsigned PW_IDLE_MS = 64'd15000;
    localparam longint unsigned LD_ON_MS = 64'd200;
    localparam longint unsigned LD_OFF_MS = 64'd3000;
    // Cycle counts derived from the times (least times round up).
    localparam longint unsigned PW_HOLD_CYC =
        (PW_HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam longint unsigned PW_IDLE_CYC =
        (PW_IDLE_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam longint unsigned LD_ON_CYC =
        (LD_ON_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam longint unsigned LD_OFF_CYC =
        (LD_OFF_MS * CLK_HZ + 64'd999) / 64'd1000;
    // Width of the shared timer.
    localparam int TMR_W = 32;
    // Current limit select encoding.
    localparam logic [1:0] LIM_NONE = 2'h0;
    localparam logic [1:0] LIM_LOW = 2'h1;
    localparam logic [1:0] LIM_HIGH = 2'h2;
    localparam logic [1:0] LIM_PW = 2'h3;
    // Interrupt status bit positions.
    localparam int EV_MODE = 0;
    localparam int EV_LOAD_ON = 1;
    localparam int EV_LOAD_OFF = 2;
    localparam int EV_W = 3;
    // Register offsets.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CLEAR = 4'h4;
    localparam logic [3:0] REG_ENABLE = 4'h8;
    localparam logic [3:0] REG_MODE = 4'hc;
    // Reset values.
    localparam logic [EV_W-1:0] ENABLE_RST = 3'h0;
    // Charging modes.
    typedef enum logic [3:0] {
        MD_DISCHARGE,
        MD_AUTO,
        MD_AUTO_PW,
        MD_AUTO_KB,
        MD_AUTO_KB_LD,
        MD_SDP_A,
        MD_SDP_B,
        MD_SHORTED,
        MD_DIVIDER,
        MD_CDP
    } cmsld_mode_t;
    // Power wake states.
    typedef enum logic [1:0] {
        PW_IDLE,
        PW_HOLD,
        PW_CHARGE
    } cmsld_pw_t;
endpackage
`default_nettype wire

/* verilog/cmsld_top.sv */
// Purpose: Decode mode pins into charging mode, limit, switch and load flag.
// Assumes: Pins are asynchronous; comparator levels come from analog.
// Notes:   Analog signatures and protection live outside this block.
//
// Overview of operation
// R1: Track pins continuously unless HID wake holds.
// R2: Host may change pins freely after wake.
// R3: Code 000 discharges, no limit, no load.
// R4: 001/0: auto charging, high limit, no load.
// R5: 001/1: auto charging with power wake detect.
// R6: Power wake toggles power wake and high limits.
// R7: 011/1: keyboard wake, high limit, load thresholds.
// R8: 011/0: keyboard wake, high limit, no load.
// R9: 010/110: port A, data on, limit follows select.
// R10: 100: shorted charging, limit follows select.
// R11: 101: divider charging, limit follows select.
// R12: 111/0: port B, data on, low limit.
// R13: 111/1: charging downstream port, high limit.
// R14: Downstream port load on threshold or detection.
// R15: 1111 to 1110 swaps skip discharge.
// R16: Power wake releases load below 45mA.
// R17: Load in power wake: assert, hold output 2s.
// R18: Below 45mA for 15s: 55mA limit, release.
// R19: Load on after 200ms, off after 3s.
//
// Added by the designer: the register offsets and the plain strobed port.
`default_nettype none
module cmsld_top
    import cmsld_pkg::*;
#(
    parameter longint unsigned HOLD_CYC = PW_HOLD_CYC,
    parameter longint unsigned IDLE_CYC = PW_IDLE_CYC,
    parameter longint unsigned ON_CYC   = LD_ON_CYC,
    parameter longint unsigned OFF_CYC  = LD_OFF_CYC
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rstn,
    // Mode pins from the system controller.
    input  wire logic             mode_select_a,
    input  wire logic             mode_select_b,
    input  wire logic             mode_select_c,
    input  wire logic             limit_select,
    // Analog comparators and detectors.
    input  wire logic             load_above_hi,
    input  wire logic             load_below_lo,
    input  wire logic             load_below_pw,
    input  wire logic             pw_limit_hit,
    input  wire logic             primary_detect,
    input  wire logic             hid_hold,
    // Register port.
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output var  logic [31:0]      reg_rdata,
    // Port control outputs.
    output var  logic             port_power_on,
    output var  logic             port_discharge,
    output var  logic             data_switch_on,
    output var  logic [1:0]       limit_sel,
    output var  logic             load_present_n,
    output var  logic             irq
);
    // Complete state of the block.
    typedef struct packed {
        logic [3:0]       s1;       // First synchroniser stage.
        logic [3:0]       s2;       // Second synchroniser stage.
        logic [5:0]       a1;       // Comparator first stage.
        logic [5:0]       a2;       // Comparator second stage.
        cmsld_mode_t      mode;     // Current charging mode.
        cmsld_pw_t        pw;       // Power wake state.
        logic [TMR_W-1:0] pw_tmr;   // Power wake timer.
        logic [TMR_W-1:0] ld_tmr;   // Load threshold timer.
        logic             load;     // Load present, active high.
        logic             dis;      // Output discharge in progress.
        logic [EV_W-1:0]  stat;     // Sticky event flags.
        logic [EV_W-1:0]  en;       // Interrupt enables.
        logic [31:0]      rdata;    // Read data.
        logic             pon;      // Port power on.
        logic             pdis;     // Port discharge, inverse of pon.
        logic             dsw;      // Data switch.
        logic [1:0]       lim;      // Limit select out.
        logic             ldn;      // Load output, active low.
        logic             irq;      // Interrupt output.
    } cmsld_state_t;


    // One comb process fills st_d.
    // One flop process stores it.
    cmsld_state_t st_q;   // Registered state.
    cmsld_state_t st_d;   // Next state.

    // Pins decoded into a requested mode.
    cmsld_mode_t req;
    // Mode code, pin a first.
    logic [2:0]  code;
    // Limit select pin.
    logic        sel;
    // Heavy load seen.
    logic        hi;
    // Light load seen.
    logic        blo;
    // Below wake floor.
    logic        bpw;
    // Small limit hit.
    logic        hit;
    // Primary detection.
    logic        pdet;
    // HID device held.
    logic        hid;
    // Events this cycle.
    logic [EV_W-1:0] ev;

    // Synchronised pin fields.
    assign code = st_q.s2[3:1];
    assign sel  = st_q.s2[0];

    // Analog levels, also after two flops.
    assign hi   = st_q.a2[0];
    assign blo  = st_q.a2[1];
    assign bpw  = st_q.a2[2];
    assign hit  = st_q.a2[3];
    assign pdet = st_q.a2[4];
    assign hid  = st_q.a2[5];

    // Truth table decode of the mode pins.
    // The HID hold-off is applied later.
    always_comb begin
        case (code)
            3'h0: req = MD_DISCHARGE;                    // R3
            3'h1: req = sel ? MD_AUTO_PW : MD_AUTO;      // R4 R5
            3'h2: req = MD_SDP_A;                        // R9
            3'h3: req = sel ? MD_AUTO_KB_LD : MD_AUTO_KB; // R7 R8
            3'h4: req = MD_SHORTED;                      // R10
            3'h5: req = MD_DIVIDER;                      // R11
            // Code 110 is port A as well.
            3'h6: req = MD_SDP_A;                        // R9
            3'h7: req = sel ? MD_CDP : MD_SDP_B;         // R12 R13
            // Never reached; kept safe.
            default: req = MD_DISCHARGE;
        endcase
    end

    // Next state: mode tracking, load detection, outputs, registers.
    always_comb begin
        // Move blocked by HID.
        logic lock;
        // Port B swap.
        logic swap;
        // Mode move taken.
        logic change;
        // Wanted load level.
        logic want;

        // Hold all unless set below.
        st_d = st_q;
        lock = 1'b0;
        swap = 1'b0;
        change = 1'b0;
        want = 1'b0;
        ev = '0;

        // Pins pass two flops before any logic reads them.
        // Both stages load every cycle.
        st_d.s1 = {mode_select_a, mode_select_b, mode_select_c,
                   limit_select};
        st_d.s2 = st_q.s1;
        st_d.a1 = {hid_hold, primary_detect, pw_limit_hit,
                   load_below_pw, load_below_lo, load_above_hi};
        st_d.a2 = st_q.a1;

        // A recognised HID device pins port A, port B or the downstream port while a wake move is asked.
        // Other moves still pass.
        lock = hid && (req == MD_AUTO_KB || req == MD_AUTO_KB_LD) &&
               (st_q.mode == MD_SDP_A || st_q.mode == MD_SDP_B ||
                st_q.mode == MD_CDP);                                // R1
        change = (req != st_q.mode) && !lock;                      // R1 R2
        // Port B and downstream port swap without a discharge.
        swap = (req == MD_CDP && st_q.mode == MD_SDP_B) ||
               (req == MD_SDP_B && st_q.mode == MD_CDP);            // R15

        // A move restarts all timers and
        // drops the load flag.
        if (change) begin
            st_d.mode = req;
            st_d.pw = PW_CHARGE;
            st_d.pw_tmr = '0;
            st_d.ld_tmr = '0;
            st_d.load = 1'b0;
            st_d.dis = !swap && req != MD_DISCHARGE;                // R15
            // Software sees every move.
            ev[EV_MODE] = 1'b1;
        end else begin
            // Discharge lasts one cycle.
            st_d.dis = 1'b0;
            // Steady mode: load logic.
            case (st_q.mode)
                MD_AUTO_PW: begin
                    case (st_q.pw)
                        // Main supply in use.
                        PW_CHARGE: begin
                            st_d.load = 1'b1;
                            // Light load counts to idle.
                            if (bpw) begin                          // R16
                                st_d.pw_tmr = st_q.pw_tmr + 1'b1;
                                if (st_q.pw_tmr >= TMR_W'(IDLE_CYC)) begin
                                    st_d.pw = PW_IDLE;              // R18
                                    st_d.load = 1'b0;
                                    st_d.pw_tmr = '0;
                                end
                            end else begin
                                st_d.pw_tmr = '0;
                            end
                        end
                        // Low-power supply in use.
                        PW_IDLE: begin
                            st_d.load = 1'b0;
                            // A hit means a new load.
                            if (hit) begin                          // R17
                                st_d.pw = PW_HOLD;
                                st_d.load = 1'b1;
                                st_d.pw_tmr = '0;
                            end
                        end
                        // Output off while supply starts.
                        PW_HOLD: begin
                            st_d.load = 1'b1;
                            st_d.pw_tmr = st_q.pw_tmr + 1'b1;
                            if (st_q.pw_tmr >= TMR_W'(HOLD_CYC - 1)) begin
                                st_d.pw = PW_CHARGE;                // R17
                                st_d.pw_tmr = '0;
                            end
                        end
                        // Unused code.
                        default: st_d.pw = PW_CHARGE;
                    endcase
                end
                // One shared timer; a turn of
                // direction restarts it.
                MD_AUTO_KB_LD, MD_CDP: begin
                    // Threshold qualification with hysteresis times.
                    want = st_q.load ? !blo : hi;                   // R19
                    // Detection skips the filter.
                    if (st_q.mode == MD_CDP && pdet) begin
                        st_d.load = 1'b1;                           // R14
                        st_d.ld_tmr = '0;
                    end else if (want != st_q.load) begin
                        st_d.ld_tmr = st_q.ld_tmr + 1'b1;
                        if (!st_q.load &&
                            st_q.ld_tmr >= TMR_W'(ON_CYC - 1)) begin
                            st_d.load = 1'b1;                       // R19
                            st_d.ld_tmr = '0;
                        end else if (st_q.load &&
                            st_q.ld_tmr >= TMR_W'(OFF_CYC - 1)) begin
                            st_d.load = 1'b0;                       // R19
                            st_d.ld_tmr = '0;
                        end
                    end else begin
                        st_d.ld_tmr = '0;
                    end
                end
                // No load detection here.
                default: begin
                    st_d.load = 1'b0;                          // R4 R8 R12
                    st_d.ld_tmr = '0;
                end
            endcase
        end

        // Load edges raise events.
        if (st_d.load && !st_q.load) ev[EV_LOAD_ON] = 1'b1;
        if (!st_d.load && st_q.load) ev[EV_LOAD_OFF] = 1'b1;
        // Output stage, registered straight from the next state.
        st_d.ldn = !st_d.load;
        st_d.pon = st_d.mode != MD_DISCHARGE && !st_d.dis &&
                   !(st_d.mode == MD_AUTO_PW && st_d.pw == PW_HOLD); // R3 R17
        // Own flop, so no gate at the pin.
        st_d.pdis = !st_d.pon;
        // Data lines off in discharge.
        st_d.dsw = st_d.pon && (st_d.mode == MD_SDP_A ||
                   st_d.mode == MD_SDP_B || st_d.mode == MD_CDP);   // R9 R13

        // Limit for the settled mode.
        case (st_d.mode)
            MD_DISCHARGE: st_d.lim = LIM_NONE;                      // R3
            MD_AUTO, MD_AUTO_KB, MD_AUTO_KB_LD, MD_CDP:
                st_d.lim = LIM_HIGH;                        // R4 R7 R13
            MD_AUTO_PW:
                st_d.lim = (st_d.pw == PW_IDLE) ? LIM_PW : LIM_HIGH; // R6
            MD_SDP_B: st_d.lim = LIM_LOW;                           // R12
            default: st_d.lim = st_q.s2[0] ? LIM_HIGH : LIM_LOW;   // R10 R11
        endcase
        // Register writes; a new event wins over a clear.
        if (reg_wr && reg_addr == REG_CLEAR)
            st_d.stat = st_q.stat & ~reg_wdata[EV_W-1:0];
        // Enables are read-write.
        if (reg_wr && reg_addr == REG_ENABLE)
            st_d.en = reg_wdata[EV_W-1:0];
        st_d.stat = st_d.stat | ev;
        // Rises with its own event.
        st_d.irq = |(st_d.stat & st_d.en);

        // Reads answer next cycle; unmapped and write-only read zero.
        // No stale word lingers.
        st_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: st_d.rdata = {29'h0, st_q.stat};
                REG_ENABLE: st_d.rdata = {29'h0, st_q.en};
                REG_MODE:   st_d.rdata = {24'h0, st_q.pw, st_q.load,
                                          st_q.dis, st_q.mode};
                default:    st_d.rdata = '0;
            endcase
        end
    end

    // Every output is a state field,
    // so all come from flops.
    // Single state register; synchronous reset to discharge.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q <= '0;
            st_q.mode <= MD_DISCHARGE;
            st_q.pw <= PW_CHARGE;
            st_q.en <= ENABLE_RST;
            st_q.ldn <= 1'b1;
            // Port held off in reset.
            st_q.pdis <= 1'b1;
            st_q.lim <= LIM_NONE;
        end else begin
            st_q <= st_d;
        end
    end


    // Outputs straight from flops.
    assign reg_rdata      = st_q.rdata;
    assign port_power_on  = st_q.pon;
    assign port_discharge = st_q.pdis;
    assign data_switch_on = st_q.dsw;
    assign limit_sel      = st_q.lim;
    assign load_present_n = st_q.ldn;
    assign irq            = st_q.irq;
endmodule
`default_nettype wire

/* verif/cmsld_top_sva.sv */
// Purpose: Concurrent checks on the charge mode select block ports.
// Assumes: Pins are held at least a dozen cycles between changes.
// Notes:   Settled outputs are judged after eight stable pin cycles.
`default_nettype none
module cmsld_top_sva
    import cmsld_pkg::*;
#(
    parameter longint unsigned HOLD_CYC = PW_HOLD_CYC,
    parameter longint unsigned ON_CYC   = LD_ON_CYC
) (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        rstn,
    // Mode pins and comparators.
    input wire logic        mode_select_a,
    input wire logic        mode_select_b,
    input wire logic        mode_select_c,
    input wire logic        limit_select,
    input wire logic        load_above_hi,
    input wire logic        pw_limit_hit,
    // Port control outputs.
    input wire logic        port_power_on,
    input wire logic        data_switch_on,
    input wire logic [1:0]  limit_sel,
    input wire logic        load_present_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [3:0]  code;      // Pin code, limit select last.
    logic [31:0] hi_cnt;    // Consecutive cycles of a heavy load.
    logic [31:0] hold_cnt;  // Cycles since a power wake limit hit.
    logic        hold_act;  // A power wake hold is being timed.
    assign code = {mode_select_a, mode_select_b, mode_select_c, limit_select};
    // Helper counters; the hold is armed only once, so a lingering hit
    // cannot restart it and shorten the measured hold.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hi_cnt <= 32'h0;
            hold_cnt <= 32'h0;
            hold_act <= 1'b0;
        end else begin
            hi_cnt <= load_above_hi ? hi_cnt + 32'h1 : 32'h0;
            hold_cnt <= hold_act ? hold_cnt + 32'h1 : 32'h0;
            if (pw_limit_hit && limit_sel == LIM_PW && port_power_on) begin
                hold_act <= 1'b1;
            end else if (port_power_on) begin
                hold_act <= 1'b0;
            end
        end
    end
    disch_mode_a: assert property ((code == 4'h0)[*8] |-> !port_power_on
        && limit_sel == LIM_NONE && load_present_n && !data_switch_on)
        else $error("discharge code left port active");
    data_on_a: assert property ((code[3:1] inside {3'h2, 3'h6, 3'h7}
        && $stable(code))[*8] |-> data_switch_on)
        else $error("data lines off in a data port code");
    data_off_a: assert property ((code[3:1] inside {3'h1, 3'h4, 3'h5}
        && $stable(code))[*8] |-> !data_switch_on)
        else $error("data lines on in a dedicated code");
    lim_follow_a: assert property ((code[3:1] inside {3'h2, 3'h4, 3'h5,
        3'h6} && $stable(code))[*8] |->
        limit_sel == (code[0] ? LIM_HIGH : LIM_LOW))
        else $error("limit does not follow limit select");
    sdpb_low_a: assert property ((code == 4'he)[*8] |->
        limit_sel == LIM_LOW && load_present_n)
        else $error("port B limit or load flag wrong");
    no_disch_a: assert property ({$past(code), code} inside {8'hfe, 8'hef}
        && port_power_on |=> port_power_on[*6])
        else $error("port output dropped between 1111 and 1110");
    pw_hold_a: assert property (pw_limit_hit && limit_sel == LIM_PW
        && port_power_on |-> ##[1:6] (!load_present_n && !port_power_on))
        else $error("limit hit did not assert load and hold output");
    hold_len_a: assert property ($rose(port_power_on) && hold_act |->
        hold_cnt >= HOLD_CYC && hold_cnt <= HOLD_CYC + 8)
        else $error("power wake hold length wrong");
    ld_on_a: assert property ($fell(load_present_n) && code == 4'h7 |->
        hi_cnt >= ON_CYC)
        else $error("load flag asserted before the filter time");
    cover property (!load_present_n && code == 4'h7);
    cover property ($rose(port_power_on) && hold_act);
    cover property (limit_sel == LIM_PW);
endmodule
bind cmsld_top cmsld_top_sva #(.HOLD_CYC(HOLD_CYC), .ON_CYC(ON_CYC))
    cmsld_top_sva_inst (.clock, .rstn, .mode_select_a, .mode_select_b,
    .mode_select_c, .limit_select, .load_above_hi, .pw_limit_hit,
    .port_power_on, .data_switch_on, .limit_sel, .load_present_n);
`default_nettype wire

/* verif/cmsld_dev_model.sv */
// Purpose: Portable device on the charging port, seen through comparators.
// Assumes: Draw 0 none, 1 trickle, 2 moderate, 3 heavy.
// Notes:   A device with no supply draws nothing at all.
`default_nettype none
module cmsld_dev_model
    import cmsld_pkg::*;
(
    // Clock and bench commands.
    input  wire logic       clock,
    input  wire logic [1:0] draw,
    input  wire logic       attach_bc,
    // Port state.
    input  wire logic       port_power_on,
    input  wire logic       data_switch_on,
    input  wire logic [1:0] limit_sel,
    // Comparator levels.
    output var  logic       load_above_hi,
    output var  logic       load_below_lo,
    output var  logic       load_below_pw,
    output var  logic       pw_limit_hit,
    output var  logic       primary_detect
);
    initial {load_above_hi, load_below_lo, load_below_pw} = 3'h0;
    initial {pw_limit_hit, primary_detect} = 2'h0;
    // Levels follow the draw one cycle late, like a slow analog path.
    always @(posedge clock) begin
        load_above_hi <= port_power_on && draw == 2'h3;
        load_below_lo <= !port_power_on || draw < 2'h2;
        load_below_pw <= !port_power_on || draw == 2'h0;
        // Only a moderate or heavy load can trip the small limit.
        pw_limit_hit <= port_power_on && limit_sel == LIM_PW && draw >= 2'h2;
        primary_detect <= attach_bc && data_switch_on && port_power_on;
    end
endmodule
`default_nettype wire

/* verif/tb_cmsld_top.sv */
// Purpose: Self-checking bench for the charge mode select block.
// Assumes: Counts are shortened through the design parameters.
// Notes:   Expected pin states are built from the mode table, plus literal states for load and power wake.
`default_nettype none
module tb_cmsld_top;
    import cmsld_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 20, IC = 30, OC = 5, FC = 8;
    // Bench stimulus and scoreboard state.
    logic clock = 1'b0, rstn = 1'b0, hid_hold = 1'b0, reg_wr = 1'b0;
    logic reg_rd = 1'b0, attach_bc = 1'b0, snap = 1'b0, rd_q = 1'b0;
    logic [3:0] code = 4'h0, reg_addr = 4'h0;
    logic [1:0] draw = 2'h2;
    logic [31:0] reg_wdata = 32'h0, got, rnd, exp_q[$];
    int error_cnt = 0, samples_checked = 0, cyc = 0, off_cnt = 0, base;
    // Mode pins, design and model outputs.
    wire logic mode_select_a, mode_select_b, mode_select_c, limit_select;
    wire logic port_power_on, port_discharge, data_switch_on, load_present_n;
    wire logic irq, load_above_hi, load_below_lo, load_below_pw;
    wire logic pw_limit_hit, primary_detect;
    wire logic [1:0] limit_sel;
    wire logic [31:0] reg_rdata;
    wire logic [6:0] pins = {irq, port_power_on, port_discharge,
        data_switch_on, limit_sel, load_present_n};
    assign {mode_select_a, mode_select_b, mode_select_c, limit_select} = code;
    cmsld_top #(.HOLD_CYC(HC), .IDLE_CYC(IC), .ON_CYC(OC), .OFF_CYC(FC))
        cmsld_top_inst (.clock, .rstn, .mode_select_a, .mode_select_b,
        .mode_select_c, .limit_select, .load_above_hi, .load_below_lo,
        .load_below_pw, .pw_limit_hit, .primary_detect, .hid_hold, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_power_on,
        .port_discharge, .data_switch_on, .limit_sel, .load_present_n, .irq);
    cmsld_dev_model cmsld_dev_model_inst (.clock, .draw, .attach_bc,
        .port_power_on, .data_switch_on, .limit_sel, .load_above_hi,
        .load_below_lo, .load_below_pw, .pw_limit_hit, .primary_detect);
    initial forever #5 clock = ~clock;
    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Queue a pin expectation; the monitor samples it at the next negedge.
    task automatic see(logic [6:0] e);
        exp_q.push_back({25'h0, e});
        snap <= 1'b1;
        tick(1);
        snap <= 1'b0;
        tick(1);
    endtask
    // Both strobes are dropped with a spare cycle so calls never collide.
    task automatic wr(logic [3:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
    endtask
    task automatic setc(logic [3:0] c);
        code <= c;
        tick(12);
    endtask
    // Settled pins for a code with a moderate load and no events enabled.
    function automatic logic [6:0] mode_pins(logic [3:0] c);
        logic [1:0] l;
        l = (c[0] || c[3:1] inside {3'h1, 3'h3}) ? LIM_HIGH : LIM_LOW;
        if (c[3:1] == 3'h0)
            return 7'h11;
        return {2'b01, 1'b0, c[3:1] inside {3'h2, 3'h6, 3'h7}, l, c != 4'h3};
    endfunction
    // Cycle count, power-off tally and a ceiling against hangs.
    always @(posedge clock) begin
        cyc++;
        if (port_power_on !== 1'b1) off_cnt++;
        rd_q <= reg_rd;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // Monitor: any read answer or pin snapshot takes the oldest note.
    always @(negedge clock) begin
        if (rd_q || snap) begin
            got = rd_q ? reg_rdata : {25'h0, pins};
            check(got, exp_q.pop_front());
        end
    end
    initial begin
        rnd = $urandom(32'hbf9d85ae);
        tick(6);
        rstn <= 1'b1;
        tick(2);
        see(7'h11);
        for (int i = 0; i < 16; i++) begin
            setc(4'(i + rnd));
            see(mode_pins(code));
        end
        setc(4'hf);
        base = off_cnt;
        setc(4'he);
        setc(4'hf);
        check(off_cnt - base, 0);
        setc(4'h7);
        check(off_cnt - base > 0, 1);
        wr(REG_CLEAR, 32'h7);
        draw <= 2'h3;
        tick(OC - 2);
        see(mode_pins(4'h7));
        tick(OC + 6);
        see(7'h24);
        draw <= 2'h1;
        tick(FC - 2);
        see(7'h24);
        tick(FC + 6);
        see(mode_pins(4'h7));
        rd(REG_STATUS, 32'h6);
        wr(REG_ENABLE, 32'h2);
        see(mode_pins(4'h7) | 7'h40);
        wr(REG_CLEAR, 32'h2);
        see(mode_pins(4'h7));
        rnd = $urandom;
        wr(REG_ENABLE, rnd);
        rd(REG_ENABLE, {29'h0, rnd[2:0]});
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS, 32'h4);
        rd(REG_CLEAR, 32'h0);
        rd(4'h2, 32'h0);
        rd(REG_MODE, {24'h0, PW_CHARGE, 2'h0, MD_AUTO_KB_LD});
        wr(REG_ENABLE, 32'h0);
        setc(4'hf);
        attach_bc <= 1'b1;
        tick(6);
        see(7'h2c);
        attach_bc <= 1'b0;
        setc(4'he);
        hid_hold <= 1'b1;
        setc(4'h6);
        see(mode_pins(4'he));
        hid_hold <= 1'b0;
        tick(12);
        see(mode_pins(4'h6));
        draw <= 2'h2;
        setc(4'h3);
        see(mode_pins(4'h3));
        draw <= 2'h0;
        tick(IC + 12);
        see(7'h27);
        base = off_cnt;
        draw <= 2'h3;
        tick(HC + 12);
        see(7'h24);
        check(off_cnt - base >= HC, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
